// [uip_pkg.sv]
// Package of constants and types for the UART interrupt prioritizer.
package uip_pkg;

    // ------------------------------------------------------------
    // Register addresses on the three-bit channel register bus
    // ------------------------------------------------------------
    localparam logic [2:0] UIP_ADDR_HOLDING = 3'h0; // Receive holding read, transmit write.
    localparam logic [2:0] UIP_ADDR_MASK = 3'h1; // Interrupt mask register.
    localparam logic [2:0] UIP_ADDR_SOURCE = 3'h2; // Interrupt source register.
    localparam logic [2:0] UIP_ADDR_LINE = 3'h5; // Line status register.
    localparam logic [2:0] UIP_ADDR_MODEM = 3'h6; // Modem status register.

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int UIP_MASK_RXDATA = 0; // Receive data enable bit.
    localparam int UIP_MASK_TRANSMIT_READY_EVENT = 1; // Transmit ready enable bit.
    localparam int UIP_MASK_LINE = 2; // Line status enable bit.
    localparam int UIP_MASK_MODEM = 3; // Modem status enable bit.
    localparam logic [3:0] UIP_MASK_RESET = 4'h0; // All sources disabled after reset.
    localparam logic [3:0] UIP_MASK_USED = 4'hf; // Writable low nibble of the mask.
    localparam logic [1:0] UIP_SOURCE_RSVD = 2'h0; // Bits 5 and 4 of the source register.

    // ------------------------------------------------------------
    // Source codes in bits 3:0 of the interrupt source register
    // ------------------------------------------------------------
    localparam logic [3:0] UIP_CODE_LINE = 4'h6; // Line status, highest priority.
    localparam logic [3:0] UIP_CODE_TIMEOUT = 4'hc; // Receive data timeout.
    localparam logic [3:0] UIP_CODE_RXDATA = 4'h4; // Receive data ready.
    localparam logic [3:0] UIP_CODE_TRANSMIT_READY_EVENT = 4'h2; // Transmit ready.
    localparam logic [3:0] UIP_CODE_MODEM = 4'h0; // Modem status, lowest priority.
    localparam logic [3:0] UIP_CODE_NONE = 4'h1; // Nothing pending, also the reset value.

    // ------------------------------------------------------------
    // Receive trigger levels selected by the two-bit field
    // ------------------------------------------------------------
    localparam logic [4:0] UIP_TRIG_SEL0 = 5'h01; // Trigger at 1 character.
    localparam logic [4:0] UIP_TRIG_SEL1 = 5'h04; // Trigger at 4 characters.
    localparam logic [4:0] UIP_TRIG_SEL2 = 5'h08; // Trigger at 8 characters.
    localparam logic [4:0] UIP_TRIG_SEL3 = 5'h0e; // Trigger at 14 characters.

    // ------------------------------------------------------------
    // Receive timeout span: characters plus extra bit times
    // ------------------------------------------------------------
    localparam logic [6:0] UIP_TOUT_CHARS = 7'h04; // Character times in the span.
    localparam logic [6:0] UIP_TOUT_BITS = 7'h0c; // Extra bit times in the span.

    // Pending source selected by the priority encoder.
    typedef enum logic [2:0] {
        UIP_SRC_NONE,
        UIP_SRC_LINE,
        UIP_SRC_TIMEOUT,
        UIP_SRC_RXDATA,
        UIP_SRC_TRANSMIT_READY_EVENT,
        UIP_SRC_MODEM
    } uip_src_e;

endpackage

// [uip_prioritizer.sv]
// Interrupt mask, prioritized source and line status logic of one UART channel.
module uip_prioritizer
    import uip_pkg::*;
(
    input wire logic sys_clk, // Channel clock, 25 MHz.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic [2:0] reg_addr, // Register address.
    input wire logic reg_rd, // Read strobe, one cycle.
    input wire logic reg_wr, // Write strobe, one cycle.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic divisor_sel, // Divisor latch access selected, hides these registers.
    output logic [7:0] reg_rdata, // Read data, valid the cycle after the strobe.
    output logic reg_rhit, // This block answered the read of the previous cycle.
    input wire logic fifo_enable, // FIFOs enabled.
    input wire logic [1:0] rx_trigger_sel, // Receive trigger select field.
    input wire logic [4:0] rx_fifo_count, // Receive FIFO fill.
    input wire logic rx_holding_full, // Holding register full in non-FIFO mode.
    input wire logic rx_char_loaded, // Character moved from shift register, one cycle.
    input wire logic rx_head_update, // New character at holding position, one cycle.
    input wire logic rx_head_parity_err, // Parity error of the character at the head.
    input wire logic rx_head_framing_err, // Framing error of the character at the head.
    input wire logic rx_head_break, // Break of the character at the head.
    input wire logic rx_overrun_event, // Receive overrun, one cycle.
    input wire logic rx_fifo_error_any, // Some character in the FIFO has an error.
    input wire logic tx_fifo_empty, // Transmit holding or FIFO empty.
    input wire logic tx_all_empty, // Transmit FIFO and shift register empty.
    input wire logic [3:0] modem_lines, // Current modem input levels.
    input wire logic [3:0] modem_change, // Modem input change events, one cycle each.
    input wire logic bit_tick, // One pulse per bit time.
    input wire logic [3:0] char_bits, // Bit times in one character frame.
    output logic irq // Channel interrupt request, active high.
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------

    // Returns true for an access to the given address with divisor access off.
    function automatic logic hit(input logic [2:0] a, input logic [2:0] target,
                                 input logic dsel);
        hit = (a == target) && !dsel;
    endfunction

    // Maps the trigger select field to a character count.
    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        if (sel == 2'h0) begin
            trig_level = UIP_TRIG_SEL0;
        end else if (sel == 2'h1) begin
            trig_level = UIP_TRIG_SEL1;
        end else if (sel == 2'h2) begin
            trig_level = UIP_TRIG_SEL2;
        end else begin
            trig_level = UIP_TRIG_SEL3;
        end
    endfunction

    wire logic rhr_rd = reg_rd && hit(reg_addr, UIP_ADDR_HOLDING, divisor_sel); // Holding read.
    wire logic thr_wr = reg_wr && hit(reg_addr, UIP_ADDR_HOLDING, divisor_sel); // Holding write.
    wire logic mask_wr = reg_wr && hit(reg_addr, UIP_ADDR_MASK, divisor_sel); // Mask write.
    wire logic mask_rd = reg_rd && hit(reg_addr, UIP_ADDR_MASK, divisor_sel); // Mask read.
    wire logic src_rd = reg_rd && hit(reg_addr, UIP_ADDR_SOURCE, divisor_sel); // Source read.
    wire logic lsr_rd = reg_rd && hit(reg_addr, UIP_ADDR_LINE, divisor_sel); // Line read.
    wire logic msr_rd = reg_rd && hit(reg_addr, UIP_ADDR_MODEM, divisor_sel); // Modem read.

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    logic [3:0] mask_ff; // Interrupt mask, low nibble only.
    logic overrun_ff; // Sticky overrun.
    logic [2:0] head_err_ff; // Sticky break, framing and parity of the head byte.
    logic [3:0] modem_delta_ff; // Sticky modem change bits.
    logic tx_pend_ff; // Transmit ready pending.
    logic tx_empty_q_ff; // Last value of the transmit empty condition.
    logic tout_pend_ff; // Receive timeout pending.
    logic [6:0] tout_cnt_ff; // Idle bit times counted.
    logic [7:0] rdata_ff; // Captured read data.
    logic rhit_ff; // Read hit captured.
    logic irq_ff; // Registered interrupt request.

    // ------------------------------------------------------------
    // Line status composition
    // ------------------------------------------------------------
    wire logic data_ready = fifo_enable ? (rx_fifo_count != 5'h00) : rx_holding_full;
    wire logic fifo_err_bit = fifo_enable && rx_fifo_error_any;
    wire logic [7:0] lsr_val = {fifo_err_bit, tx_all_empty, tx_fifo_empty, head_err_ff,
                                overrun_ff, data_ready};
    wire logic [7:0] msr_val = {modem_lines, modem_delta_ff}; // Modem status view.

    // ------------------------------------------------------------
    // Source conditions after masking
    // ------------------------------------------------------------
    wire logic [4:0] trig = trig_level(rx_trigger_sel);
    wire logic rx_cond = fifo_enable ? (rx_fifo_count >= trig) : rx_holding_full;
    wire logic line_pend = mask_ff[UIP_MASK_LINE] && (overrun_ff || (|head_err_ff));
    wire logic tout_pend = mask_ff[UIP_MASK_RXDATA] && tout_pend_ff;
    wire logic rx_pend = mask_ff[UIP_MASK_RXDATA] && rx_cond;
    wire logic tx_pend = mask_ff[UIP_MASK_TRANSMIT_READY_EVENT] && tx_pend_ff;
    wire logic modem_pend = mask_ff[UIP_MASK_MODEM] && (|modem_delta_ff);

    // ------------------------------------------------------------
    // Priority encoder
    // ------------------------------------------------------------
    uip_src_e src; // Highest pending source.

    // Picks the one source reported, the others wait behind it.
    always_comb begin
        if (line_pend) begin
            src = UIP_SRC_LINE;
        end else if (tout_pend) begin
            src = UIP_SRC_TIMEOUT;
        end else if (rx_pend) begin
            src = UIP_SRC_RXDATA;
        end else if (tx_pend) begin
            src = UIP_SRC_TRANSMIT_READY_EVENT;
        end else if (modem_pend) begin
            src = UIP_SRC_MODEM;
        end else begin
            src = UIP_SRC_NONE;
        end
    end

    logic [3:0] src_code; // Code placed in bits 3:0.

    // Translates the chosen source into its register code.
    always_comb begin
        case (src)
            UIP_SRC_LINE: src_code = UIP_CODE_LINE;
            UIP_SRC_TIMEOUT: src_code = UIP_CODE_TIMEOUT;
            UIP_SRC_RXDATA: src_code = UIP_CODE_RXDATA;
            UIP_SRC_TRANSMIT_READY_EVENT: src_code = UIP_CODE_TRANSMIT_READY_EVENT;
            UIP_SRC_MODEM: src_code = UIP_CODE_MODEM;
            default: src_code = UIP_CODE_NONE;
        endcase
    end

    wire logic [7:0] isr_val = {fifo_enable, fifo_enable, UIP_SOURCE_RSVD, src_code};
    wire logic any_pend = (src != UIP_SRC_NONE);

    // ------------------------------------------------------------
    // Next values of the sticky flags
    // ------------------------------------------------------------
    wire logic [2:0] head_err_in = {rx_head_break, rx_head_framing_err, rx_head_parity_err};
    // A set in the same cycle as the clearing read wins.
    wire logic nxt_overrun = rx_overrun_event || (overrun_ff && !lsr_rd);
    wire logic [2:0] nxt_head_err = (rx_head_update ? head_err_in : 3'h0)
                                    | (lsr_rd ? 3'h0 : head_err_ff);
    wire logic [3:0] nxt_modem_delta = modem_change | (msr_rd ? 4'h0 : modem_delta_ff);
    // The empty history resets low, so an empty transmit FIFO at reset sets the flag.
    wire logic tx_rise = tx_fifo_empty && !tx_empty_q_ff;
    wire logic tx_enable_set = mask_wr && reg_wdata[UIP_MASK_TRANSMIT_READY_EVENT]
                               && !mask_ff[UIP_MASK_TRANSMIT_READY_EVENT] && tx_fifo_empty;
    wire logic tx_clear = thr_wr || (src_rd && (src == UIP_SRC_TRANSMIT_READY_EVENT));
    wire logic nxt_tx_pend = tx_rise || tx_enable_set || (tx_pend_ff && !tx_clear);

    // ------------------------------------------------------------
    // Receive timeout timer
    // ------------------------------------------------------------
    // The timer runs only while FIFO mode holds data; a load or holding read restarts it.
    wire logic [6:0] tout_span = 7'(UIP_TOUT_CHARS * {3'h0, char_bits}) + UIP_TOUT_BITS;
    wire logic tout_restart = rx_char_loaded || rhr_rd || !fifo_enable
                              || (rx_fifo_count == 5'h00);
    wire logic tout_expire = !tout_restart && bit_tick
                             && (tout_cnt_ff == 7'(tout_span - 7'h01));
    wire logic [6:0] nxt_tout_cnt = tout_restart ? 7'h00 :
                                    (bit_tick && !tout_expire) ? 7'(tout_cnt_ff + 7'h01) :
                                    tout_cnt_ff;
    wire logic nxt_tout_pend = tout_expire || (tout_pend_ff && !rhr_rd);

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    // Unowned addresses load zero so an old value never shows through.
    wire logic any_rd = mask_rd || src_rd || lsr_rd || msr_rd; // Reads this block answers.
    wire logic [7:0] nxt_rdata = mask_rd ? {4'h0, mask_ff} :
                                 src_rd ? isr_val :
                                 lsr_rd ? lsr_val :
                                 msr_rd ? msr_val : 8'h00;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Interrupt mask, only the low nibble is stored.
    // Reserved upper bits are never stored, so they always read back as zero.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            mask_ff <= UIP_MASK_RESET;
        end else if (mask_wr) begin
            mask_ff <= reg_wdata[3:0] & UIP_MASK_USED;
        end
    end

    // Sticky receive error and modem change flags.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            overrun_ff <= 1'b0;
            head_err_ff <= 3'h0;
            modem_delta_ff <= 4'h0;
        end else begin
            overrun_ff <= nxt_overrun;
            head_err_ff <= nxt_head_err;
            modem_delta_ff <= nxt_modem_delta;
        end
    end

    // Transmit ready and timeout pending flags and the idle timer.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tx_pend_ff <= 1'b0;
            tx_empty_q_ff <= 1'b0;
            tout_pend_ff <= 1'b0;
            tout_cnt_ff <= 7'h00;
        end else begin
            tx_pend_ff <= nxt_tx_pend;
            tx_empty_q_ff <= tx_fifo_empty;
            tout_pend_ff <= nxt_tout_pend;
            tout_cnt_ff <= nxt_tout_cnt;
        end
    end

    // Read data capture and registered interrupt request.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
            rhit_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
            rhit_ff <= any_rd;
            irq_ff <= any_pend;
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rhit = rhit_ff;
    assign irq = irq_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Every check runs on the channel clock and rests while reset is held.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Line status read with no new overrun or head byte in the same cycle.
    sequence s_lsr_idle;
        lsr_rd && !rx_overrun_event && !rx_head_update;
    endsequence

    a_rx_trigger_code: assert property (
        fifo_enable && mask_ff[UIP_MASK_RXDATA] && (rx_fifo_count >= trig)
        && !line_pend && !tout_pend |-> src_code == UIP_CODE_RXDATA)
        else $error("receive trigger did not give the data ready code");

    a_rx_below_clear: assert property (
        fifo_enable && (rx_fifo_count < trig) && !line_pend && !tout_pend && !tx_pend
        && !modem_pend |-> isr_val[3:0] == UIP_CODE_NONE ##1 !irq)
        else $error("source code or request stayed up below trigger");

    a_rx_holding: assert property (
        !fifo_enable && mask_ff[UIP_MASK_RXDATA] && rx_holding_full && !line_pend
        && !tout_pend |-> src_code == UIP_CODE_RXDATA)
        else $error("full holding register did not give the data ready code");

    a_data_ready_bit: assert property (
        fifo_enable && rx_char_loaded |=> lsr_val[0] || (rx_fifo_count == 5'h00))
        else $error("data ready did not follow the FIFO fill");

    a_polled_quiet: assert property (mask_ff == 4'h0 |=> !irq)
        else $error("request raised with every source disabled");

    a_tx_on_enable: assert property (tx_enable_set && !thr_wr |=> tx_pend_ff)
        else $error("transmit ready not raised on enable while empty");

    a_overrun_fast: assert property (
        rx_overrun_event && mask_ff[UIP_MASK_LINE] && !mask_wr
        |=> src_code == UIP_CODE_LINE ##1 irq)
        else $error("overrun did not raise the line status source at once");

    a_modem_raise: assert property (
        mask_ff[UIP_MASK_MODEM] && (|modem_change) && !mask_wr |=> any_pend)
        else $error("modem change did not raise a pending source");

    a_mask_reserved: assert property (mask_rd |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved mask bits read non-zero");

    a_line_clear: assert property (s_lsr_idle |=> !line_pend)
        else $error("line status source survived the line status read");

    a_line_view: assert property (
        lsr_rd |=> reg_rdata[7] == $past(fifo_err_bit) && reg_rdata[1] == $past(overrun_ff))
        else $error("line status read does not show the FIFO error and overrun");

    a_modem_clear: assert property (
        msr_rd && !(|modem_change) |=> modem_delta_ff == 4'h0)
        else $error("modem change bits survived the modem status read");

    a_tout_clear: assert property (rhr_rd && !tout_expire |=> !tout_pend_ff)
        else $error("timeout survived a holding register read");

    a_tx_clear: assert property (thr_wr && !tx_rise |=> !tx_pend_ff)
        else $error("transmit ready survived a holding write");

    a_source_top: assert property (
        src_rd |=> reg_rdata[7:4] == {$past(fifo_enable), $past(fifo_enable), 2'h0})
        else $error("source register upper bits wrong");

    a_pending_bit: assert property (
        src_rd |=> reg_rdata[0] == !$past(any_pend))
        else $error("source bit 0 does not show the pending state");

    a_irq_follow: assert property (any_pend ##1 any_pend |-> irq)
        else $error("request low while a source is pending");

endmodule

// [uip_host_model.sv]
// Host processor model that reaches the channel registers over the parallel bus.
module uip_host_model (
    input wire logic sys_clk,
    output logic [2:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // -------------------------------------------------------
    // Bus idle state and access tasks
    // -------------------------------------------------------
    // The bus starts idle with both strobes low.
    initial begin
        reg_addr = 3'h0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // One read: the strobe is taken at the next edge and the data stands from then on.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask

    // One write: the address is scrambled after release so stale values never help.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// [uip_prioritizer_tb_top.sv]
// Self-checking testbench of the UART interrupt prioritizer.
module uip_prioritizer_tb_top;
    import uip_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, nrst, reg_rd, reg_wr, divisor_sel, reg_rhit, irq, fifo_enable;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, r;
    logic [1:0] rx_trigger_sel;
    logic [4:0] rx_fifo_count;
    logic rx_holding_full, rx_char_loaded, rx_head_update, rx_head_parity_err;
    logic rx_head_framing_err, rx_head_break, rx_overrun_event, rx_fifo_error_any;
    logic tx_fifo_empty, tx_all_empty, bit_tick;
    logic [3:0] modem_lines, modem_change, char_bits;
    int seed, miscompares, check_count, lvl;

    uip_prioritizer DUT (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .divisor_sel(divisor_sel),
        .reg_rdata(reg_rdata), .reg_rhit(reg_rhit), .fifo_enable(fifo_enable),
        .rx_trigger_sel(rx_trigger_sel), .rx_fifo_count(rx_fifo_count),
        .rx_holding_full(rx_holding_full), .rx_char_loaded(rx_char_loaded),
        .rx_head_update(rx_head_update), .rx_head_parity_err(rx_head_parity_err),
        .rx_head_framing_err(rx_head_framing_err), .rx_head_break(rx_head_break),
        .rx_overrun_event(rx_overrun_event), .rx_fifo_error_any(rx_fifo_error_any),
        .tx_fifo_empty(tx_fifo_empty), .tx_all_empty(tx_all_empty),
        .modem_lines(modem_lines), .modem_change(modem_change), .bit_tick(bit_tick),
        .char_bits(char_bits), .irq(irq)
    );
    uip_host_model host (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
    );

    // -------------------------------------------------------
    // Clock, watchdog and helpers
    // -------------------------------------------------------
    // The 25 MHz channel clock.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end

    // Trigger level chosen by the two-bit select field.
    function automatic int trig(input logic [1:0] s);
        case (s)
            2'h0: return 1;
            2'h1: return 4;
            2'h2: return 8;
            default: return 14;
        endcase
    endfunction

    // Source register value: FIFO status twice, zero pair, priority code.
    function automatic logic [7:0] src(input logic [3:0] c);
        return {fifo_enable, fifo_enable, 2'b00, c};
    endfunction

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
        logic [7:0] v;
        host.rd(a, v);
        chk(n, e, v);
        chk("read_hit", 8'h01, {7'h00, reg_rhit});
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // -------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------
    initial begin
        seed = 27145;
        {nrst, divisor_sel, fifo_enable, rx_trigger_sel, rx_fifo_count} = '0;
        {rx_holding_full, rx_char_loaded, rx_head_update, rx_head_parity_err} = '0;
        {rx_head_framing_err, rx_head_break, rx_overrun_event, rx_fifo_error_any} = '0;
        {tx_all_empty, bit_tick, modem_lines, modem_change} = '0;
        tx_fifo_empty = 1'b1;
        char_bits = 4'ha;
        repeat (4) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        rdc(UIP_ADDR_MASK, 8'h00, "mask_reset");
        rdc(UIP_ADDR_SOURCE, 8'h01, "source_reset");
        // Transmit ready already empty when enabled, upper mask bits dropped.
        host.wr(UIP_ADDR_MASK, 8'hf2);
        rdc(UIP_ADDR_MASK, 8'h02, "mask_reserved");
        chk("irq_tx", 8'h01, {7'h00, irq});
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_TRANSMIT_READY_EVENT), "tx_on_enable");
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_NONE), "tx_read_clear");
        tx_fifo_empty = 1'b0;
        tick();
        tx_fifo_empty = 1'b1;
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_TRANSMIT_READY_EVENT), "tx_empty_edge");
        // A fresh empty edge leaves transmit ready pending for the holding write to clear.
        tx_fifo_empty = 1'b0;
        tick();
        tx_fifo_empty = 1'b1;
        tick();
        host.wr(UIP_ADDR_HOLDING, 8'($random(seed)));
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_NONE), "tx_write_clear");
        // Non-FIFO receive holding interrupt, then trigger levels in FIFO mode.
        host.wr(UIP_ADDR_MASK, 8'h01);
        rx_holding_full = 1'b1;
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_RXDATA), "holding_full");
        rx_holding_full = 1'b0;
        fifo_enable = 1'b1;
        for (int s = 0; s < 4; s++) begin
            rx_trigger_sel = 2'(s);
            lvl = trig(2'(s));
            rx_fifo_count = 5'(lvl);
            rdc(UIP_ADDR_SOURCE, src(UIP_CODE_RXDATA), "at_trigger");
            rx_fifo_count = 5'(lvl - 1);
            rdc(UIP_ADDR_SOURCE, src(UIP_CODE_NONE), "below_trigger");
        end
        // Line status beats receive data; random head errors land in the line bits.
        rx_trigger_sel = 2'h1;
        rx_fifo_count = 5'h04;
        host.wr(UIP_ADDR_MASK, 8'h05);
        r = 8'($random(seed));
        {rx_head_break, rx_head_framing_err, rx_head_parity_err} = r[2:0];
        {rx_fifo_error_any, tx_all_empty, tx_fifo_empty} = r[7:5];
        {rx_overrun_event, rx_head_update, rx_char_loaded} = 3'h7;
        tick();
        {rx_overrun_event, rx_head_update, rx_char_loaded} = 3'h0;
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_LINE), "line_first");
        rdc(UIP_ADDR_LINE, {r[7:5], r[2:0], 2'b11}, "line_bits");
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_RXDATA), "queued_next");
        // Modem change with random deltas; the modem read clears it.
        rx_fifo_count = 5'h00;
        host.wr(UIP_ADDR_MASK, 8'h08);
        r = 8'($random(seed));
        modem_lines = r[7:4];
        modem_change = r[3:0] | 4'h1;
        tick();
        modem_change = 4'h0;
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_MODEM), "modem_pend");
        rdc(UIP_ADDR_MODEM, {r[7:4], r[3:0] | 4'h1}, "modem_bits");
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_NONE), "modem_clear");
        // Receive timeout after four characters plus twelve bit times.
        host.wr(UIP_ADDR_MASK, 8'h01);
        rx_fifo_count = 5'h01;
        rx_char_loaded = 1'b1;
        tick();
        rx_char_loaded = 1'b0;
        bit_tick = 1'b1;
        repeat (int'(UIP_TOUT_CHARS) * int'(char_bits) + int'(UIP_TOUT_BITS) - 1) tick();
        bit_tick = 1'b0;
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_NONE), "timeout_early");
        bit_tick = 1'b1;
        tick();
        bit_tick = 1'b0;
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_TIMEOUT), "timeout_hit");
        host.rd(UIP_ADDR_HOLDING, d);
        chk("holding_data", 8'h00, d);
        chk("holding_hit", 8'h00, {7'h00, reg_rhit});
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_NONE), "timeout_clear");
        // All enables cleared: polled mode raises nothing.
        rx_fifo_count = 5'h04;
        host.wr(UIP_ADDR_MASK, 8'h00);
        rdc(UIP_ADDR_SOURCE, src(UIP_CODE_NONE), "polled_src");
        chk("polled_irq", 8'h00, {7'h00, irq});
        // Divisor access hides the mask: the write is dropped and the read gives zero.
        divisor_sel = 1'b1;
        host.wr(UIP_ADDR_MASK, 8'h0f);
        host.rd(UIP_ADDR_MASK, d);
        chk("divisor_data", 8'h00, d);
        chk("divisor_hit", 8'h00, {7'h00, reg_rhit});
        divisor_sel = 1'b0;
        rdc(UIP_ADDR_MASK, 8'h00, "divisor_no_write");
        summarize();
    end
endmodule
